// file: rtl/mdc_coproc.sv
/*
 * Coprocessor end: mode word, two 32-bit result registers, one-cycle multiply
 * and accumulate, and a radix-4 divider of 17 cycles per request.
 * Assumes the processor end holds req with stable operands until taken.
 */
// Summary of operation
// - Single-cycle 16x16 multiply, signed or unsigned.
// - Single-cycle multiply-accumulate with signed overflow detection.
// - 32/32 divide, quotient and remainder, 17-20 cycles.
// - Processor avoids divide overflow and divide-by-zero.
// - Mode write stores seven low operand bits.
// - Mode bits 6:4 pick returned half-word.
// - Clear, 16-bit, 32-bit A and B loads.
// - Codes 4-9 multiply, accumulate, divide; codes 11-15 reserved.
// - Code 3 returns selected half, no arithmetic.
// - Preload: first operand high, second low.
// - Multiply writes A, returns half, clears flags.
// - Divide: quotient to A, remainder to B.
// - Divide returns any selected quotient or remainder half.
// - Result registers hold until overwritten.
// - Multiply sequence: mode, operate, read.
// - Mode 0x13 then operate reads A high.
// - Divide sequence: preload dividend, mode, operate.
// - Remainder read through modes 0x23, 0x33.
// - Accumulate adds product into A.
// - Signed accumulate overflow gives flags 0100.
// - Overflow clears on any later operate, read included, or preload.
// - Read mode keeps registers, clears flags.
`timescale 1ns/1ps
module mdc_coproc
    import mdc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    mdc_link_if.dev link,
    output logic [6:0] o_mode,
    output logic o_div_busy
);
    // Divider states.
    typedef enum logic [1:0] {
        MDC_IDLE = 2'b00,
        MDC_RUN = 2'b01,
        MDC_FIX = 2'b10
    } mdc_state_t;

    logic [6:0] mode_r; // Stored mode word.
    logic [31:0] res_a_r; // Result register A.
    logic [31:0] res_b_r; // Result register B.
    logic [3:0] flags_r; // Flags returned with the last answer.
    logic [15:0] out_r; // Returned half-word.
    logic ack_r; // Answer strobe.
    mdc_state_t state_r; // Divider state.
    logic [4:0] cnt_r; // Divider step counter.
    logic [31:0] quo_r; // Quotient being built, dividend bits shift out.
    logic [32:0] rem_r; // Partial remainder.
    logic [31:0] dvs_r; // Magnitude of the divisor.
    logic neg_q_r; // Quotient must be negated at the end.
    logic neg_r_r; // Remainder must be negated at the end.

    wire [3:0] opc = mode_r[3:0];
    wire [2:0] sel = mode_r[6:4];
    wire take = i_ce && link.req && (state_r == MDC_IDLE);
    wire is_op = take && (link.cmd == CMD_OPERATE);
    wire is_pre = take && (link.cmd == CMD_PRELOAD);
    wire is_mode = take && (link.cmd == CMD_MODE);
    wire is_signed = opc[0];

    // Product of the two operands, each extended by one bit: with its sign in signed modes, with zero otherwise.
    logic signed [33:0] prod;
    logic [31:0] mac_sum;
    logic mac_ovf;
    always_comb begin
        prod = $signed({is_signed & link.op_first[15], link.op_first})
             * $signed({is_signed & link.op_second[15], link.op_second});
        mac_sum = res_a_r + prod[31:0];
        // Overflow only in signed mode: like signs added give the other sign.
        mac_ovf = (opc == OPC_MACS) && (prod[31] == res_a_r[31])
                  && (mac_sum[31] != res_a_r[31]);
    end

    // Radix-4 division retires two quotient bits per cycle by two chained
    // restoring steps; a negative difference keeps the shifted remainder.
    logic [32:0] sh1, df1, rs1;
    logic [32:0] sh2, df2, rs2;
    logic qb1, qb2;
    always_comb begin
        sh1 = {rem_r[31:0], quo_r[31]};
        df1 = sh1 - {1'b0, dvs_r};
        qb1 = !df1[32];
        rs1 = qb1 ? df1 : sh1;
        sh2 = {rs1[31:0], quo_r[30]};
        df2 = sh2 - {1'b0, dvs_r};
        qb2 = !df2[32];
        rs2 = qb2 ? df2 : sh2;
    end

    // Mode word, written only by the mode-write instruction.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_r <= MODE_RST;
        end else if (is_mode) begin
            mode_r <= link.op_second[6:0];
        end
    end

    // Divider sequencer; its busy state holds off every new instruction.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= MDC_IDLE;
            cnt_r <= 5'h00;
            quo_r <= RES_RST;
            rem_r <= 33'h0_0000_0000;
            dvs_r <= RES_RST;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
        end else if (i_ce) begin
            case (state_r)
                MDC_IDLE: begin
                    if (is_op && (opc == OPC_DIVU || opc == OPC_DIVS)) begin
                        // Signed operands are made positive first; no zero check.
                        neg_q_r <= is_signed && (res_a_r[31] ^ link.op_first[15]);
                        neg_r_r <= is_signed && res_a_r[31];
                        quo_r <= (is_signed && res_a_r[31]) ? -res_a_r : res_a_r;
                        dvs_r <= (is_signed && link.op_first[15])
                                 ? -{link.op_first, link.op_second}
                                 : {link.op_first, link.op_second};
                        rem_r <= 33'h0_0000_0000;
                        cnt_r <= 5'h00;
                        state_r <= MDC_RUN;
                    end
                end
                MDC_RUN: begin
                    rem_r <= rs2;
                    quo_r <= {quo_r[29:0], qb1, qb2};
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == DIV_STEPS_M1) begin
                        state_r <= MDC_FIX;
                    end
                end
                default: begin
                    state_r <= MDC_IDLE;
                end
            endcase
        end
    end

    // Result registers; anything not named here leaves them untouched.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            res_a_r <= RES_RST;
            res_b_r <= RES_RST;
        end else if (i_ce) begin
            if (is_mode && link.op_second[3:0] == OPC_CLEAR) begin
                res_a_r <= RES_RST;
                res_b_r <= RES_RST;
            end else if (is_pre && opc == OPC_LOAD16) begin
                res_a_r <= {16'h0000, link.op_second};
            end else if (is_pre && opc == OPC_LOAD32A) begin
                res_a_r <= {link.op_first, link.op_second};
            end else if (is_pre && opc == OPC_LOAD32B) begin
                res_b_r <= {link.op_first, link.op_second};
            end else if (is_op && (opc == OPC_MULU || opc == OPC_MULS)) begin
                res_a_r <= prod[31:0];
            end else if (is_op && (opc == OPC_MACU || opc == OPC_MACS)) begin
                res_a_r <= mac_sum;
            end else if (state_r == MDC_FIX) begin
                res_a_r <= neg_q_r ? -quo_r : quo_r;
                res_b_r <= neg_r_r ? -rem_r[31:0] : rem_r[31:0];
            end
            // Otherwise both hold, including read mode.
        end
    end

    // Answer: selected half of the next register value, with flags.
    logic [31:0] a_next, b_next;
    always_comb begin
        a_next = res_a_r;
        b_next = res_b_r;
        if (is_op && (opc == OPC_MULU || opc == OPC_MULS)) begin
            a_next = prod[31:0];
        end else if (is_op && (opc == OPC_MACU || opc == OPC_MACS)) begin
            a_next = mac_sum;
        end else if (state_r == MDC_FIX) begin
            a_next = neg_q_r ? -quo_r : quo_r;
            b_next = neg_r_r ? -rem_r[31:0] : rem_r[31:0];
        end
    end

    // Codes 0-7 answer at once, divides in the fix cycle, codes 11-15 with the held half-word; code 10 gets no answer.
    wire op_ok = is_op && (opc <= OPC_MACS);
    wire op_valid = (op_ok || state_r == MDC_FIX) && (sel <= SEL_B_HI);
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_r <= 1'b0;
            out_r <= 16'h0000;
            flags_r <= FLAGS_CLEAR;
        end else if (i_ce) begin
            ack_r <= op_ok || state_r == MDC_FIX || (is_op && opc > OPC_LOAD32B);
            if (op_valid) begin
                if (sel == SEL_A_LO) begin
                    out_r <= a_next[15:0];
                end else if (sel == SEL_A_HI) begin
                    out_r <= a_next[31:16];
                end else if (sel == SEL_B_LO) begin
                    out_r <= b_next[15:0];
                end else begin
                    out_r <= b_next[31:16];
                end
            end
            if (is_op && opc == OPC_MACS) begin
                flags_r <= mac_ovf ? FLAGS_OVF : FLAGS_CLEAR;
            end else if (is_op || is_pre) begin
                flags_r <= FLAGS_CLEAR;
            end
        end
    end

    assign link.busy = (state_r != MDC_IDLE);
    assign link.ack = ack_r && i_ce;
    assign link.result = out_r;
    assign link.flags = flags_r;
    assign o_mode = mode_r;
    assign o_div_busy = (state_r != MDC_IDLE);
endmodule

// file: rtl/mdc_cpu_end.sv
/*
 * Processor end: turns user requests into link instructions and returns answers.
 * Assumes the user holds i_req until o_taken and waits for o_done on operates.
 */
`timescale 1ns/1ps
module mdc_cpu_end
    import mdc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_req,
    input wire logic [1:0] i_cmd,
    input wire logic [15:0] i_first,
    input wire logic [15:0] i_second,
    output logic o_taken,
    output logic o_done,
    output logic [15:0] o_result,
    output logic [3:0] o_flags,
    mdc_link_if.cpu link
);
    logic [15:0] res_r; // Last returned half-word.
    logic [3:0] flg_r; // Last returned flags.
    logic done_r; // Answer strobe toward the user.

    // Instructions pass straight through; the device's busy stalls them.
    assign link.req = i_req && i_ce;
    assign link.cmd = i_cmd;
    assign link.op_first = i_first;
    // Mode writes carry only seven bits.
    assign link.op_second = (i_cmd == CMD_MODE) ? {9'h000, i_second[6:0]} : i_second;
    assign o_taken = i_req && i_ce && !link.busy;

    // Capture each answer; the user follows the documented sequences.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            res_r <= 16'h0000;
            flg_r <= FLAGS_CLEAR;
            done_r <= 1'b0;
        end else if (i_ce) begin
            done_r <= link.ack;
            if (link.ack) begin
                res_r <= link.result;
                flg_r <= link.flags;
            end
        end
    end
    assign o_done = done_r;
    assign o_result = res_r;
    assign o_flags = flg_r;
endmodule

// file: rtl/mdc_link_if.sv
/*
 * Link between the processor end and the coprocessor end.
 * Assumes one shared clock; the testbench instantiates it and joins both ends.
 */
`timescale 1ns/1ps
interface mdc_link_if;
    logic req; // Instruction strobe from the processor, held until taken.
    logic [1:0] cmd; // Instruction kind.
    logic [15:0] op_first; // First operand (destination register value).
    logic [15:0] op_second; // Second operand or immediate.
    logic busy; // Coprocessor is holding off the processor.
    logic ack; // One-cycle pulse: result and flags are valid.
    logic [15:0] result; // Returned half-word.
    logic [3:0] flags; // Returned condition flags, C V Z N.
    modport dev (input req, cmd, op_first, op_second, output busy, ack, result, flags);
    modport cpu (output req, cmd, op_first, op_second, input busy, ack, result, flags);
endinterface

// file: rtl/mdc_pkg.sv
/*
 * Shared constants for the multiply, accumulate and divide coprocessor link.
 * Assumes both ends include this package before the interface and modules.
 */
package mdc_pkg;
    // Widths of the mode word and its two fields.
    localparam int MODE_W = 7;
    localparam int OUTSEL_LSB = 4;
    localparam int OUTSEL_W = 3;
    localparam int OPC_W = 4;
    // Operation codes held in mode bits 3 to 0.
    localparam logic [3:0] OPC_CLEAR = 4'h0;
    localparam logic [3:0] OPC_LOAD16 = 4'h1;
    localparam logic [3:0] OPC_LOAD32A = 4'h2;
    localparam logic [3:0] OPC_READ = 4'h3;
    localparam logic [3:0] OPC_MULU = 4'h4;
    localparam logic [3:0] OPC_MULS = 4'h5;
    localparam logic [3:0] OPC_MACU = 4'h6;
    localparam logic [3:0] OPC_MACS = 4'h7;
    localparam logic [3:0] OPC_DIVU = 4'h8;
    localparam logic [3:0] OPC_DIVS = 4'h9;
    localparam logic [3:0] OPC_LOAD32B = 4'ha;
    // Output selector values held in mode bits 6 to 4.
    localparam logic [2:0] SEL_A_LO = 3'h0;
    localparam logic [2:0] SEL_A_HI = 3'h1;
    localparam logic [2:0] SEL_B_LO = 3'h2;
    localparam logic [2:0] SEL_B_HI = 3'h3;
    // Reset values and flag patterns, ordered C V Z N.
    localparam logic [6:0] MODE_RST = 7'h00;
    localparam logic [31:0] RES_RST = 32'h0000_0000;
    localparam logic [3:0] FLAGS_CLEAR = 4'h0;
    localparam logic [3:0] FLAGS_OVF = 4'h4;
    // Division timing: 16 radix-4 steps plus one load cycle and sign fix.
    localparam int DIV_STEPS = 16;
    localparam logic [4:0] DIV_STEPS_M1 = 5'h0f;
    // Instruction kinds carried on the link.
    localparam logic [1:0] CMD_MODE = 2'h0;
    localparam logic [1:0] CMD_OPERATE = 2'h1;
    localparam logic [1:0] CMD_PRELOAD = 2'h2;
endpackage

// file: testbench/mdc_link_asserts.sv
/* Checker for the processor-to-coprocessor link, fed with the link signals.
   Assumes the clock enable is held high, so any request seen while idle is taken. */
`timescale 1ns/1ps
module mdc_link_asserts
    import mdc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic req,
    input wire logic [1:0] cmd,
    input wire logic [15:0] op_first,
    input wire logic [15:0] op_second,
    input wire logic busy,
    input wire logic ack,
    input wire logic [15:0] result,
    input wire logic [3:0] flags
);
    logic [6:0] mode_r; // Shadow of the mode word, which the link never echoes.
    logic [31:0] prod_r; // Unsigned product of last cycle's operands.
    logic tk; // A request is taken in this cycle.
    logic [3:0] opc; // Operation code of the shadowed mode.
    logic opr; // A taken operate instruction.
    assign tk = req && !busy;
    assign opc = mode_r[3:0];
    assign opr = tk && cmd == CMD_OPERATE;
    // Track mode writes so each answer can be judged by the mode in force.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_r <= MODE_RST;
        end else if (tk && cmd == CMD_MODE) begin
            mode_r <= op_second[6:0];
        end
    end
    // The product is delayed a cycle so it lines up with the answer.
    always_ff @(posedge i_sys_clk) begin
        prod_r <= 32'(op_first) * 32'(op_second);
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    chk_fast_answer: assert property (opr && opc < 4'h8 |=> ack)
        else $error("operate got no answer in the next cycle");
    chk_mul_value: assert property (opr && opc == OPC_MULU && mode_r[6:5] == 2'h0 |=>
        result == (mode_r[4] ? prod_r[31:16] : prod_r[15:0]) && flags == FLAGS_CLEAR)
        else $error("unsigned product half or flags wrong");
    chk_div_hold: assert property (opr && (opc == OPC_DIVU || opc == OPC_DIVS) |=>
        busy [*8] ##1 busy [*8] ##1 busy ##1 ack)
        else $error("divide did not hold the link busy until its answer");
    chk_div_time: assert property (opr && (opc == OPC_DIVU || opc == OPC_DIVS) |->
        ##[17:20] ack)
        else $error("divide answer outside its cycle window");
    chk_quiet_cmds: assert property (tk && cmd != CMD_OPERATE |=> !ack)
        else $error("mode or preload produced an answer");
    chk_read_flags: assert property (opr && opc == OPC_READ |=> ack && flags == FLAGS_CLEAR)
        else $error("result read left flags set");
    chk_result_hold: assert property (1'b1 |=> ack || $stable(result))
        else $error("returned value moved without an answer");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("answer strobe longer than one cycle");
    chk_reserved_keep: assert property (opr && opc > OPC_LOAD32B |=> ack && $stable(result))
        else $error("reserved operation changed the returned value");
endmodule

// file: testbench/mul_div_mac_coprocessor_test.sv
/* Self-checking bench: both link ends joined, driven through the processor end.
   Assumes one 20 MHz clock; the clock enable is high except in one freeze test. */
`timescale 1ns/1ps
module mul_div_mac_coprocessor_test
    import mdc_pkg::*;
;
    logic i_sys_clk;
    logic i_nrst;
    logic i_ce; // Shared clock enable of both ends.
    logic i_req;
    logic [1:0] i_cmd;
    logic [15:0] i_first;
    logic [15:0] i_second;
    logic o_taken;
    logic o_done;
    logic [15:0] o_result;
    logic [3:0] o_flags;
    logic [6:0] o_mode; // Mode word shown by the coprocessor end.
    logic o_div_busy; // Divider activity shown by the coprocessor end.
    int b_cnt; // Cycles the divider showed busy during the last operate.
    logic [15:0] r_res; // Last returned half-word.
    logic [3:0] r_flg; // Last returned flags.
    int num_errors;
    int checked;
    mdc_link_if link_if();
    mdc_coproc mdc_coproc_inst(.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .link(link_if.dev), .o_mode(o_mode), .o_div_busy(o_div_busy));
    mdc_cpu_end mdc_cpu_end_inst(.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_req(i_req), .i_cmd(i_cmd), .i_first(i_first), .i_second(i_second),
        .o_taken(o_taken), .o_done(o_done), .o_result(o_result), .o_flags(o_flags),
        .link(link_if.cpu));
    mdc_link_asserts mdc_link_asserts_inst(.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .req(link_if.req), .cmd(link_if.cmd), .op_first(link_if.op_first),
        .op_second(link_if.op_second), .busy(link_if.busy), .ack(link_if.ack),
        .result(link_if.result), .flags(link_if.flags));
    // Free-running 50 ns clock.
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // Compare one value and count it.
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One instruction; request held until taken, then an idle edge so the
    // strobe is never raised twice in one time step.
    task automatic xfer(input logic [1:0] c, input logic [15:0] a, input logic [15:0] b);
        int n;
        i_req = 1'b1;
        i_cmd = c;
        i_first = a;
        i_second = b;
        n = 0;
        b_cnt = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_taken !== 1'b1 && n < 100);
        @(posedge i_sys_clk);
        #1;
        i_req = 1'b0;
        // Operates answer later; a divide keeps the link busy meanwhile.
        while (c == CMD_OPERATE && o_done !== 1'b1 && n < 200) begin
            @(negedge i_sys_clk);
            n++;
            // Count the cycles in which the divider holds the link off.
            if (o_div_busy === 1'b1) begin
                b_cnt++;
            end
        end
        if (n >= 100 && (c != CMD_OPERATE || n >= 200)) begin
            num_errors++;
            report_and_stop();
        end
        r_res = o_result;
        r_flg = o_flags;
        @(posedge i_sys_clk);
        #1;
    endtask
    // Mode write with junk above bit 6, which must be dropped.
    task automatic mdo(input logic [6:0] m);
        xfer(CMD_MODE, 16'hffff, {9'h1ff, m});
    endtask
    task automatic pre(input logic [6:0] m, input logic [15:0] a, input logic [15:0] b);
        mdo(m);
        xfer(CMD_PRELOAD, a, b);
    endtask
    task automatic run(input logic [6:0] m, input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] wr, input logic [3:0] wf);
        mdo(m);
        check({9'h000, o_mode}, {9'h000, m});
        xfer(CMD_OPERATE, a, b);
        check(r_res, wr);
        check({12'h000, r_flg}, {12'h000, wf});
        // A divide must keep the link busy for its run steps plus the fix cycle.
        if (m[3:0] == OPC_DIVU || m[3:0] == OPC_DIVS) begin
            check(16'(b_cnt), 16'(DIV_STEPS + 1));
        end
    endtask
    // Clock enable low: a pending mode write must not be taken and the mode
    // word must hold, since every register of both ends is frozen.
    task automatic ce_freeze();
        i_ce = 1'b0;
        i_req = 1'b1;
        i_cmd = CMD_MODE;
        i_second = 16'h0013;
        repeat (4) @(posedge i_sys_clk);
        #1;
        check({15'h0000, o_taken}, 16'h0000);
        check({9'h000, o_mode}, 16'h0003);
        i_req = 1'b0;
        i_ce = 1'b1;
        @(posedge i_sys_clk);
        #1;
    endtask
    task automatic do_reset();
        i_nrst = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_nrst = 1'b1;
        @(posedge i_sys_clk);
        #1;
    endtask
    initial begin
        i_nrst = 1'b0;
        i_ce = 1'b1;
        i_req = 1'b0;
        i_cmd = CMD_MODE;
        i_first = 16'h0000;
        i_second = 16'h0000;
        num_errors = 0;
        checked = 0;
        do_reset();
        run(7'h03, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        pre(7'h0a, 16'habcd, 16'h1234);
        run(7'h33, 16'h0000, 16'h0000, 16'habcd, 4'h0);
        run(7'h04, 16'hffff, 16'hffff, 16'h0001, 4'h0);
        run(7'h13, 16'h0000, 16'h0000, 16'hfffe, 4'h0);
        run(7'h15, 16'h8000, 16'h7fff, 16'hc000, 4'h0);
        run(7'h03, 16'h0000, 16'h0000, 16'h8000, 4'h0);
        ce_freeze();
        run(7'h03, 16'h0000, 16'h0000, 16'h8000, 4'h0);
        pre(7'h01, 16'h1111, 16'h5555);
        run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        pre(7'h02, 16'h7fff, 16'hffff);
        run(7'h07, 16'h0001, 16'h0001, 16'h0000, FLAGS_OVF);
        run(7'h07, 16'h0001, 16'h0001, 16'h0001, 4'h0);
        run(7'h16, 16'h0002, 16'h0003, 16'h8000, 4'h0);
        run(7'h06, 16'hffff, 16'hffff, 16'h0008, 4'h0);
        run(7'h0b, 16'h0005, 16'h0005, 16'h0008, 4'h0);
        pre(7'h02, 16'h0001, 16'h0007);
        run(7'h08, 16'h0000, 16'h0010, 16'h1000, 4'h0);
        run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        run(7'h23, 16'h0000, 16'h0000, 16'h0007, 4'h0);
        run(7'h33, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        pre(7'h02, 16'hffff, 16'hfff0);
        run(7'h39, 16'h0000, 16'h0003, 16'hffff, 4'h0);
        run(7'h03, 16'h0000, 16'h0000, 16'hfffb, 4'h0);
        pre(7'h02, 16'h0000, 16'h0064);
        run(7'h28, 16'h0000, 16'h0007, 16'h0002, 4'h0);
        run(7'h18, 16'h0000, 16'h0003, 16'h0000, 4'h0);
        run(7'h03, 16'h0000, 16'h0000, 16'h0004, 4'h0);
        mdo(7'h00);
        run(7'h23, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        run(7'h03, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        pre(7'h02, 16'h1234, 16'h5678);
        do_reset();
        run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
        report_and_stop();
    end
endmodule
